/* vspo_map.vh */
`ifndef VSPO_MAP_VH
`define VSPO_MAP_VH
// How it works
// - zero frequency: ramp down or stop at once
// - activation off: ramp down or stop at once
// - activation stop never sets completion flag
// - limit in travel direction stops, flags abnormal
// - busy channel refuses new positioning commands
// - direction output off when instruction finishes
// - legacy mode: no ramp at start/stop
// - one ramp enable for all channels
// - table index 1..100 plus channel runs entry
// - direction on counts up, off counts down
// - frequency magnitude 1..200000 Hz, sign direction

// ==========================================
// register offsets (byte addresses) and channel address fields
`define VSPO_CTRL          8'h00
`define VSPO_STAT          8'h04
`define VSPO_IRQ_STAT      8'h08
`define VSPO_IRQ_MASK      8'h0c
`define VSPO_TBL_SEL       8'h10
`define VSPO_TBL_WADDR     8'h14
`define VSPO_TBL_WDATA     8'h18
`define VSPO_TBL_RUN       8'h1c
`define VSPO_CH_BASE       4'h2
`define VSPO_CH_LAST       4'h5
`define VSPO_CH_FREQ       2'h0
`define VSPO_CH_CMD        2'h1
`define VSPO_CH_POS        2'h2

// ==========================================
// field positions
`define VSPO_CTRL_RAMP     0
`define VSPO_CTRL_LEGACY   1
`define VSPO_CMD_ACT       0
`define VSPO_CMD_FWD_LIM   1
`define VSPO_CMD_REV_LIM   2
`define VSPO_STAT_DONE     4
`define VSPO_STAT_ABN      5

// ==========================================
// reset values and limits
`define VSPO_CTRL_RST      2'h0
`define VSPO_TBL_MIN       32'h00000001
`define VSPO_TBL_MAX       32'h00000064
`define VSPO_MAX_HZ        32'h00030d40
`define VSPO_CLK_HZ        10000000
`define VSPO_HALF_CLK      32'h004c4b40

// ==========================================
// timing: full-scale ramp time and derived divider
`define VSPO_ACC_TIME_MS   100
`define VSPO_RAMP_DIV      ((`VSPO_ACC_TIME_MS * (`VSPO_CLK_HZ / 1000)) / 200000)
`endif

/* vspo_chan.v */
`include "vspo_map.vh"

// one pulse channel: ramp, pulse generator, position count
module vspo_chan (
    sys_clk,
    rst,
    ramp_en,
    act,
    freq_cmd,
    fwd_lim,
    rev_lim,
    pulse_q,
    dir_q,
    busy_q,
    done_ok_q,
    done_abn_q,
    pos_q
);
    input  wire        sys_clk;
    input  wire        rst;
    input  wire        ramp_en;     // shared ramp enable
    input  wire        act;         // activation contact
    input  wire [31:0] freq_cmd;    // signed frequency, Hz
    input  wire        fwd_lim;
    input  wire        rev_lim;
    output reg         pulse_q;
    output reg         dir_q;       // 1 = forward
    output reg         busy_q;
    output reg         done_ok_q;   // one-cycle completion
    output reg         done_abn_q;  // one-cycle abnormal end
    output reg  [31:0] pos_q;

    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_RUN   = 2'd1;
    localparam [1:0] ST_DECEL = 2'd2;
    localparam integer DIV_N    = `VSPO_RAMP_DIV - 1;
    localparam [2:0]   DIV_LAST = DIV_N[2:0];  // divider fits three bits

    reg  [1:0]  state_q;
    reg  [31:0] cur_q;     // present output frequency
    reg  [31:0] acc_q;     // phase accumulator
    reg  [2:0]  tick_q;    // ramp step divider
    reg         hold_q;    // blocks restart after limit
    reg         okstop_q;  // decel counts as completion
    wire        neg   = freq_cmd[31];
    wire [31:0] mag   = neg ? (32'h0 - freq_cmd) : freq_cmd;
    wire        valid = (mag != 32'h0) && (mag <= `VSPO_MAX_HZ);
    wire [31:0] tgt   = (valid && (neg != dir_q)) ? mag : 32'h0;
    wire        lim   = dir_q ? fwd_lim : rev_lim;
    wire        tick  = (tick_q == DIV_LAST);
    wire [31:0] sum   = acc_q + cur_q;

    // ==========================================
    // finish: back to idle with direction off
    task finish;
        input ok;
        input abn;
        begin
            state_q    <= ST_IDLE;
            busy_q     <= 1'b0;
            dir_q      <= 1'b0;
            pulse_q    <= 1'b0;
            pos_q      <= pos_q;       // a rise cut off here is never counted
            cur_q      <= 32'h0;
            done_ok_q  <= ok;
            done_abn_q <= abn;
        end
    endtask

    // ==========================================
    // channel sequencer
    always @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cur_q <= 32'h0;
            acc_q <= 32'h0;
            tick_q <= 3'h0;
            hold_q <= 1'b0;
            okstop_q <= 1'b0;
            pulse_q <= 1'b0;
            dir_q <= 1'b0;
            busy_q <= 1'b0;
            done_ok_q <= 1'b0;
            done_abn_q <= 1'b0;
            pos_q <= 32'h0;
        end else begin
            done_ok_q  <= 1'b0;
            done_abn_q <= 1'b0;
            tick_q <= tick ? 3'h0 : tick_q + 3'h1;
            if (!act) begin
                hold_q <= 1'b0;
            end
            // pulse generation while running
            if (state_q != ST_IDLE) begin
                if (sum >= `VSPO_HALF_CLK) begin
                    acc_q   <= sum - `VSPO_HALF_CLK;
                    pulse_q <= ~pulse_q;
                    if (!pulse_q) begin
                        pos_q <= dir_q ? pos_q + 32'h1 : pos_q - 32'h1;
                    end
                end else begin
                    acc_q <= sum;
                end
            end
            case (state_q)
                ST_IDLE: begin
                    acc_q <= 32'h0;
                    // start from standstill; busy covers the run
                    if (act && valid && !hold_q) begin
                        state_q  <= ST_RUN;
                        busy_q   <= 1'b1;
                        dir_q    <= ~neg;
                        okstop_q <= 1'b0;
                        cur_q    <= ramp_en ? 32'h0 : mag;
                    end
                end
                ST_RUN: begin
                    if (lim) begin
                        hold_q <= 1'b1;
                        finish(1'b0, 1'b1);
                    end else if (!act) begin
                        if (ramp_en) begin
                            state_q <= ST_DECEL;
                        end else begin
                            finish(1'b0, 1'b0);
                        end
                    end else if (tgt == 32'h0) begin
                        if (ramp_en) begin
                            state_q  <= ST_DECEL;
                            okstop_q <= 1'b1;
                        end else begin
                            finish(1'b1, 1'b0);
                        end
                    end else if (!ramp_en) begin
                        cur_q <= tgt;
                    end else if (tick && cur_q < tgt) begin
                        cur_q <= cur_q + 32'h1;
                    end else if (tick && cur_q > tgt) begin
                        cur_q <= cur_q - 32'h1;
                    end
                end
                ST_DECEL: begin
                    if (!act) begin
                        okstop_q <= 1'b0;
                    end
                    if (lim) begin
                        hold_q <= 1'b1;
                        finish(1'b0, 1'b1);
                    end else if (cur_q == 32'h0) begin
                        finish(okstop_q && act, 1'b0);
                    end else if (tick) begin
                        cur_q <= cur_q - 32'h1;
                    end
                end
                default: begin
                    finish(1'b0, 1'b0);
                end
            endcase
        end
    end
endmodule

/* vspo_top.v */
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`include "vspo_map.vh"

// four-channel variable speed pulse output, wishbone slave
module vspo_top (
    sys_clk,
    rst,
    wb_adr_i,
    wb_dat_i,
    wb_sel_i,
    wb_we_i,
    wb_cyc_i,
    wb_stb_i,
    wb_dat_o,
    wb_ack_o,
    irq,
    pulse_out,
    dir_out
);
    input  wire        sys_clk;
    input  wire        rst;
    input  wire [7:0]  wb_adr_i;
    input  wire [31:0] wb_dat_i;
    input  wire [3:0]  wb_sel_i;
    input  wire        wb_we_i;
    input  wire        wb_cyc_i;
    input  wire        wb_stb_i;
    output reg  [31:0] wb_dat_o;
    output reg         wb_ack_o;
    output reg         irq;
    output wire [3:0]  pulse_out;   // from channel flops
    output wire [3:0]  dir_out;     // from channel flops

    // ==========================================
    // storage
    reg  [1:0]  ctrl_q;             // ramp enable, legacy
    reg  [11:0] irq_stat_q;         // done, abnormal, refused
    reg  [11:0] irq_mask_q;
    reg  [1:0]  tbl_sel_q;          // channel for table run
    reg  [31:0] tbl_waddr_q;        // entry being loaded
    reg  [31:0] freq_q [0:3];       // per-channel frequency
    reg  [2:0]  cmd_q [0:3];        // act, fwd limit, rev limit
    reg  [31:0] tbl_mem [0:99];     // stored frequencies
    reg         exec_complete_flag_q;
    reg         abnormal_end_flag_q;
    reg  [3:0]  busy_prev_q;        // for start detection
    reg  [31:0] rd_d;               // read mux
    reg  [11:0] set_d;              // event sets
    reg  [11:0] clr_d;              // software clears
    integer     i;

    // ==========================================
    // channel wires
    wire [3:0]  busy;
    wire [3:0]  done_ok;
    wire [3:0]  done_abn;
    wire [31:0] pos [0:3];
    wire        ramp_en;

    // ==========================================
    // bus decode
    wire        req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wr      = req && wb_we_i;
    wire [31:0] bmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire        ch_hit  = (wb_adr_i[7:4] >= `VSPO_CH_BASE) &&
                          (wb_adr_i[7:4] <= `VSPO_CH_LAST);
    wire [1:0]  ch_idx  = wb_adr_i[5:4] ^ 2'b10;
    wire [1:0]  ch_reg  = wb_adr_i[3:2];
    wire [31:0] wdat    = wb_dat_i & bmask;

    // table run: valid index and idle channel
    wire        tbl_ok  = (wdat >= `VSPO_TBL_MIN) && (wdat <= `VSPO_TBL_MAX);
    wire [6:0]  tbl_ix  = wdat[6:0] - 7'd1;
    wire        run_wr  = wr && (wb_adr_i == `VSPO_TBL_RUN);
    wire        run_go  = run_wr && tbl_ok && !busy[tbl_sel_q];
    wire        run_bad = run_wr && !run_go;
    wire        ld_wr   = wr && (wb_adr_i == `VSPO_TBL_WDATA) &&
                          (tbl_waddr_q >= `VSPO_TBL_MIN) &&
                          (tbl_waddr_q <= `VSPO_TBL_MAX);
    wire [6:0]  ld_ix   = tbl_waddr_q[6:0] - 7'd1;

    // one enable shared by all channels, legacy forces it off
    assign ramp_en = ctrl_q[`VSPO_CTRL_RAMP] && !ctrl_q[`VSPO_CTRL_LEGACY];

    // ==========================================
    // channels
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gch
            vspo_chan u_chan (
                .sys_clk    (sys_clk),
                .rst        (rst),
                .ramp_en    (ramp_en),
                .act        (cmd_q[g][`VSPO_CMD_ACT]),
                .freq_cmd   (freq_q[g]),
                .fwd_lim    (cmd_q[g][`VSPO_CMD_FWD_LIM]),
                .rev_lim    (cmd_q[g][`VSPO_CMD_REV_LIM]),
                .pulse_q    (pulse_out[g]),
                .dir_q      (dir_out[g]),
                .busy_q     (busy[g]),
                .done_ok_q  (done_ok[g]),
                .done_abn_q (done_abn[g]),
                .pos_q      (pos[g])
            );
        end
    endgenerate

    // ==========================================
    // read mux
    always @* begin
        rd_d = 32'h0;
        if (ch_hit) begin
            // per-channel block
            case (ch_reg)
                `VSPO_CH_FREQ: rd_d = freq_q[ch_idx];
                `VSPO_CH_CMD:  rd_d = {29'h0, cmd_q[ch_idx]};
                `VSPO_CH_POS:  rd_d = pos[ch_idx];
                default:       rd_d = 32'h0;
            endcase
        end else begin
            // global block, unmapped reads zero
            case (wb_adr_i)
                `VSPO_CTRL:      rd_d = {30'h0, ctrl_q};
                `VSPO_STAT:      rd_d = {26'h0, abnormal_end_flag_q,
                                         exec_complete_flag_q, busy};
                `VSPO_IRQ_STAT:  rd_d = {20'h0, irq_stat_q};
                `VSPO_IRQ_MASK:  rd_d = {20'h0, irq_mask_q};
                `VSPO_TBL_SEL:   rd_d = {30'h0, tbl_sel_q};
                `VSPO_TBL_WADDR: rd_d = tbl_waddr_q;
                default:         rd_d = 32'h0;
            endcase
        end
    end

    // ==========================================
    // event sets and write-one clears
    always @* begin
        set_d = {run_bad ? 4'h1 << tbl_sel_q : 4'h0, done_abn, done_ok};
        clr_d = 12'h0;
        if (wr && wb_adr_i == `VSPO_IRQ_STAT) begin
            clr_d = wdat[11:0];
        end
    end

    // ==========================================
    // bus handshake: ack one cycle after request
    always @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= rd_d;
            end
        end
    end

    // ==========================================
    // global registers, events, interrupt
    always @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= `VSPO_CTRL_RST;
            irq_stat_q <= 12'h0;
            irq_mask_q <= 12'h0;
            tbl_sel_q <= 2'h0;
            tbl_waddr_q <= 32'h0;
            exec_complete_flag_q <= 1'b0;
            abnormal_end_flag_q <= 1'b0;
            busy_prev_q <= 4'h0;
            irq <= 1'b0;
        end else begin
            // set wins over clear
            irq_stat_q <= (irq_stat_q & ~clr_d) | set_d;
            irq <= |(((irq_stat_q & ~clr_d) | set_d) & irq_mask_q);
            busy_prev_q <= busy;
            // flags follow the latest finish, cleared on a new start
            if (|done_ok) begin
                exec_complete_flag_q <= 1'b1;
            end else if (|(busy & ~busy_prev_q)) begin
                exec_complete_flag_q <= 1'b0;
            end
            if (|done_abn) begin
                abnormal_end_flag_q <= 1'b1;
            end else if (|(busy & ~busy_prev_q)) begin
                abnormal_end_flag_q <= 1'b0;
            end
            if (wr) begin
                case (wb_adr_i)
                    `VSPO_CTRL: begin
                        ctrl_q <= (ctrl_q & ~bmask[1:0]) | wdat[1:0];
                    end
                    `VSPO_IRQ_MASK: begin
                        irq_mask_q <= (irq_mask_q & ~bmask[11:0]) | wdat[11:0];
                    end
                    `VSPO_TBL_SEL: begin
                        tbl_sel_q <= (tbl_sel_q & ~bmask[1:0]) | wdat[1:0];
                    end
                    `VSPO_TBL_WADDR: begin
                        tbl_waddr_q <= (tbl_waddr_q & ~bmask) | wdat;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================
    // positioning table load
    always @(posedge sys_clk) begin
        if (ld_wr) begin
            tbl_mem[ld_ix] <= (tbl_mem[ld_ix] & ~bmask) | wdat;
        end
    end

    // ==========================================
    // per-channel frequency and command registers
    always @(posedge sys_clk) begin
        if (rst) begin
            for (i = 0; i < 4; i = i + 1) begin
                freq_q[i] <= 32'h0;
                cmd_q[i]  <= 3'h0;
            end
        end else begin
            if (wr && ch_hit && ch_reg == `VSPO_CH_FREQ) begin
                // running speed may change freely
                freq_q[ch_idx] <= (freq_q[ch_idx] & ~bmask) | wdat;
            end
            if (wr && ch_hit && ch_reg == `VSPO_CH_CMD) begin
                cmd_q[ch_idx] <= (cmd_q[ch_idx] & ~bmask[2:0]) | wdat[2:0];
            end
            if (run_go) begin
                // table entry becomes the command, activation on
                freq_q[tbl_sel_q] <= tbl_mem[tbl_ix];
                cmd_q[tbl_sel_q][`VSPO_CMD_ACT] <= 1'b1;
            end
        end
    end
endmodule

/* vspo_monitor.sv */
// ==========================================
// bus and output checker, bound to the top
module vspo_monitor (
    input wire        sys_clk,
    input wire        rst,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0]  wb_sel_i,
    input wire        wb_we_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        irq,
    input wire [3:0]  pulse_out,
    input wire [3:0]  dir_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic mask_seen_q;                                       // some mask bit ever written
    wire  taken   = wb_cyc_i && wb_stb_i && !wb_ack_o;       // request taken this edge
    wire  mask_wr = taken && wb_we_i && wb_adr_i[7:2] == 6'h03;
    sequence req_taken;
        taken;
    endsequence
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // without a mask bit the interrupt has no way up
    always @(posedge sys_clk) begin
        if (rst)
            mask_seen_q <= 1'b0;
        else if (mask_wr && wb_dat_i != 32'h0)
            mask_seen_q <= 1'b1;
    end
    chk_ack_follows: assert property (req_taken |=> ack_once)
        else $error("ack did not answer a taken request in one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack while bus idle");
    chk_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved outside an ack");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !irq && pulse_out == 4'h0 && dir_out == 4'h0)
        else $error("outputs not quiet after reset");
    chk_irq_unmasked: assert property (!mask_seen_q |-> !irq)
        else $error("interrupt raised with all masks clear");
    chk_irq_cleared: assert property (mask_wr && wb_sel_i == 4'hf && wb_dat_i == 32'h0 |-> ##[1:2] !irq)
        else $error("interrupt stayed up after masks cleared");
    for (genvar i = 0; i < 4; i++) begin : g_ch
        chk_dir_steady: assert property ($rose(pulse_out[i]) |-> $stable(dir_out[i]))
            else $error("direction changed on a counted pulse");
    end
endmodule

/* vspo_drive.sv */
// ==========================================
// drive amplifier model: counts steps per axis
module vspo_drive (
    input  wire          sys_clk,
    input  wire          rst,
    input  wire  [3:0]   pulse_out,
    input  wire  [3:0]   dir_out,
    output logic [127:0] cnt_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] pls_q;   // last pulse level
    // a rising step moves one count in the present direction
    always @(posedge sys_clk) begin
        pls_q <= pulse_out;
        for (int i = 0; i < 4; i++) begin
            if (rst)
                cnt_q[i*32 +: 32] <= 32'h0;
            else if (pulse_out[i] && !pls_q[i])
                cnt_q[i*32 +: 32] <= cnt_q[i*32 +: 32] + (dir_out[i] ? 32'h1 : 32'hffffffff);
        end
    end
endmodule

/* tb_top.sv */
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
// ==========================================
// bench top
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic         sys_clk  = 1'b0;
    logic         rst      = 1'b1;
    logic [7:0]   wb_adr_i = 8'h00;
    logic [31:0]  wb_dat_i = 32'h0;
    logic [3:0]   wb_sel_i = 4'h0;
    logic         wb_we_i  = 1'b0;
    logic         wb_cyc_i = 1'b0;
    logic         wb_stb_i = 1'b0;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic         irq;
    logic [3:0]   pulse_out;
    logic [3:0]   dir_out;
    logic [127:0] cnt_q;       // step counts seen by the drive
    logic [31:0]  rd;          // last read data
    int           n_fail  = 0;
    int           n_tests = 0;
    always #50 sys_clk = ~sys_clk;
    vspo_top u_vspo_top (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .pulse_out(pulse_out), .dir_out(dir_out));
    vspo_drive u_vspo_drive (.sys_clk(sys_clk), .rst(rst), .pulse_out(pulse_out), .dir_out(dir_out),
        .cnt_q(cnt_q));
    // ==========================================
    // bus helpers: hold the request until ack is sampled
    task automatic wb_cycle(input logic [7:0] a, input logic [31:0] d, input logic w);
        int k;
        k = 0;
        @(posedge sys_clk);
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_we_i  <= w;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            $display("[ERR] %0t no bus acknowledge", $time);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_cycle(a, d, 1'b1);
    endtask
    task automatic rdc(input logic [7:0] a);
        wb_cycle(a, 32'h0, 1'b0);
    endtask
    function automatic logic [7:0] ca(input int ch, input int off);
        return 8'(32'h20 + ch * 16 + off);
    endfunction
    // poll status until a channel busy bit reaches b
    task automatic wait_busy(input int ch, input logic b, input int lim);
        int k;
        k = 0;
        do begin
            rdc(8'h04);
            k++;
        end while (rd[ch] !== b && k < lim);
        `CHK(rd[ch], b)
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs;
        rdc(8'h00);
        `CHK(rd, 32'h0)
        wr(8'h00, 32'h3);
        rdc(8'h00);
        `CHK(rd, 32'h3)
        rdc(8'hf0);
        `CHK(rd, 32'h0)
        wr(8'h04, 32'h3f);
        rdc(8'h04);
        `CHK(rd, 32'h0)
        wr(8'h00, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_zero_stop;
        wr(ca(0, 0), 32'd20000);
        wr(ca(0, 4), 32'h1);
        wait_busy(0, 1'b1, 4);
        `CHK(dir_out[0], 1'b1)
        repeat (3000) @(posedge sys_clk);
        wr(ca(0, 0), 32'h0);
        rdc(8'h04);
        `CHK(rd[4:0], 5'h10)
        `CHK(dir_out[0], 1'b0)
        wr(ca(0, 0), 32'd20000); // busy seen low, a cycle gone
        wait_busy(0, 1'b1, 4);
        wr(ca(0, 0), 32'h0);
        wait_busy(0, 1'b0, 2);
        rdc(ca(0, 8));
        `CHK(rd, cnt_q[31:0])
        `CHK(rd != 32'h0, 1'b1)
        `CHK(irq, 1'b0)
        wr(8'h0c, 32'h1);
        rdc(8'h08);
        `CHK(rd[11:0], 12'h001)
        `CHK(irq, 1'b1)
        wr(8'h08, 32'h1);
        rdc(8'h08);
        `CHK(rd[11:0], 12'h000)
        `CHK(irq, 1'b0)
        wr(8'h0c, 32'h0);
        wr(ca(0, 4), 32'h0);
        $display("test zero stop done");
    endtask
    task automatic t_act_stop;
        wr(8'h00, 32'h1);
        wr(ca(1, 0), 32'hfffffc18); // sign held for the whole run
        wr(ca(1, 4), 32'h1);
        wait_busy(1, 1'b1, 4);
        repeat (6000) @(posedge sys_clk);
        wr(8'h14, 32'h1);
        wr(8'h18, 32'd500);
        wr(8'h10, 32'h1);
        wr(8'h1c, 32'h1);
        rdc(8'h08);
        `CHK(rd[9], 1'b1)
        `CHK(dir_out[1], 1'b0)
        wr(ca(1, 4), 32'h0);
        rdc(8'h04);
        `CHK(rd[1], 1'b1)
        wait_busy(1, 1'b0, 2500);
        `CHK(rd[4], 1'b0)
        rdc(8'h08);
        `CHK(rd[1], 1'b0)
        rdc(ca(1, 8));
        `CHK(rd, cnt_q[63:32])
        wr(8'h08, 32'hfff);
        $display("test act stop done");
    endtask
    task automatic t_limit;
        wr(ca(2, 0), 32'd5000);
        wr(ca(2, 4), 32'h1);
        wait_busy(2, 1'b1, 4);
        repeat (500) @(posedge sys_clk);
        wr(ca(2, 4), 32'h5);
        rdc(8'h04);
        `CHK(rd[2], 1'b1)
        wr(ca(2, 4), 32'h3);
        wait_busy(2, 1'b0, 2);
        rdc(8'h04);
        `CHK(rd[5], 1'b1)
        `CHK(dir_out[2], 1'b0)
        rdc(8'h08);
        `CHK(rd[6], 1'b1)
        wr(ca(2, 4), 32'h1);
        rdc(8'h04);
        `CHK(rd[2], 1'b0)
        wr(ca(2, 4), 32'h0);
        wr(8'h08, 32'hfff);
        $display("test limit done");
    endtask
    task automatic t_table;
        wr(8'h00, 32'h3);
        wr(8'h14, 32'd100);
        wr(8'h18, 32'd10000);
        wr(8'h10, 32'h3);
        wr(8'h1c, 32'd101);
        rdc(8'h08);
        `CHK(rd[11], 1'b1)
        wr(8'h08, 32'hfff);
        wr(8'h1c, 32'd100);
        wait_busy(3, 1'b1, 4);
        `CHK(dir_out[3], 1'b1)
        repeat (2500) @(posedge sys_clk);
        wr(ca(3, 4), 32'h0);
        wait_busy(3, 1'b0, 2);
        `CHK(rd[4], 1'b0)
        rdc(ca(3, 8));
        `CHK(rd, cnt_q[127:96])
        `CHK(rd != 32'h0, 1'b1)
        $display("test table done");
    endtask
    // ==========================================
    // verdict, main sequence and watchdog
    task automatic give_verdict;
        $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs;
        t_zero_stop;
        t_act_stop;
        t_limit;
        t_table;
        give_verdict;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        $display("[ERR] %0t watchdog expired", $time);
        n_fail++;
        give_verdict;
    end
endmodule
bind vspo_top vspo_monitor u_vspo_monitor (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .pulse_out(pulse_out), .dir_out(dir_out));
